// ### logic/vic_top.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module vic_top (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [vic_pkg::NODES-1:0] node_req,
   input wire logic frac_div_req,
   input wire logic lin_req,
   input wire logic [vic_pkg::NNMI-1:0] nmi_src,
   input wire logic cpu_ack,
   input wire logic cpu_reti,
   output logic vec_valid,
   output logic [15:0] vec_addr,
   output logic [2:0] act_rank,
   output logic irq
);
   import vic_pkg::*;

   logic [NA-1:0] int_enable_reg_a, next_int_enable_reg_a;
   logic [NB-1:0] int_enable_reg_b, next_int_enable_reg_b;
   logic [NNMI-1:0] nonmaskable_control_reg, next_nonmaskable_control_reg;
   logic [NA-1:0] prio_low_reg_a, next_prio_low_reg_a;
   logic [NA-1:0] prio_high_reg_a, next_prio_high_reg_a;
   logic [NB-1:0] prio_low_reg_b, next_prio_low_reg_b;
   logic [NB-1:0] prio_high_reg_b, next_prio_high_reg_b;
   logic [EV_W-1:0] status, next_status;
   logic [EV_W-1:0] mask, next_mask;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_irq;
   logic [31:0] rdata;
   logic mapped, wr;

   vic_state_t st, next_st;
   logic off_nmi, next_off_nmi;
   logic [3:0] off_idx, next_off_idx;
   logic [2:0] off_rank, next_off_rank;
   logic [ISR_W-1:0] isr, next_isr;
   logic next_vec_valid;
   logic [15:0] next_vec_addr;
   logic [2:0] next_act_rank;

   logic [NODES-1:0] req_all, en_all, pl_all, ph_all;
   logic [2:0] cur_rank;
   logic win_ok, win_nmi, still, take;
   logic [3:0] win_idx;
   logic [2:0] win_rank;
   logic [EV_W-1:0] ev;

   assign cur_rank = vic_top_rank(isr);
   assign en_all = {int_enable_reg_b, int_enable_reg_a};
   assign pl_all = {prio_low_reg_b, prio_low_reg_a};
   assign ph_all = {prio_high_reg_b, prio_high_reg_a};

   always_comb begin
      req_all = node_req;
      req_all[GRP_NODE] = node_req[GRP_NODE] | frac_div_req | lin_req;
   end

   vic_arb u_arb (
      .req(req_all),
      .en(en_all),
      .pl(pl_all),
      .ph(ph_all),
      .nmi_req(nmi_src),
      .nmi_en(nonmaskable_control_reg),
      .cur_rank(cur_rank),
      .win_ok(win_ok),
      .win_nmi(win_nmi),
      .win_idx(win_idx),
      .win_rank(win_rank)
   );

   // the offer is withdrawn if its winner changes, so a late disable holds
   // a level reprogrammed during the offer also withdraws it, so a stale rank is never pushed
   assign still = win_ok && (win_nmi == off_nmi) && (off_nmi || win_idx == off_idx)
      && win_rank == off_rank;
   assign take = (st == VIC_OFFER) && cpu_ack && still;

   always_comb begin
      next_st = st;
      next_off_nmi = off_nmi;
      next_off_idx = off_idx;
      next_off_rank = off_rank;
      next_isr = isr;
      case (st)
         VIC_IDLE: begin
            if (win_ok) begin
               next_st = VIC_OFFER;
               next_off_nmi = win_nmi;
               next_off_idx = win_idx;
               next_off_rank = win_rank;
            end
         end
         VIC_OFFER: begin
            if (take || !still) begin
               next_st = VIC_IDLE;
            end
         end
         default: begin
            next_st = VIC_IDLE;
         end
      endcase
      if (cpu_reti && cur_rank != RANK_NONE) begin
         next_isr[3'(cur_rank - 3'h1)] = 1'b0;
      end
      if (take) begin
         next_isr[3'(off_rank - 3'h1)] = 1'b1;
      end
      next_vec_valid = (next_st == VIC_OFFER);
      next_vec_addr = next_off_nmi ? VEC_NMI : vic_vec(next_off_idx);
      next_act_rank = vic_top_rank(next_isr);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st <= VIC_IDLE;
         off_nmi <= 1'b0;
         off_idx <= 4'h0;
         off_rank <= RANK_NONE;
         isr <= '0;
         vec_valid <= 1'b0;
         vec_addr <= VEC_BASE;
         act_rank <= RANK_NONE;
      end else begin
         st <= next_st;
         off_nmi <= next_off_nmi;
         off_idx <= next_off_idx;
         off_rank <= next_off_rank;
         isr <= next_isr;
         vec_valid <= next_vec_valid;
         vec_addr <= next_vec_addr;
         act_rank <= next_act_rank;
      end
   end

   // register bus: one wait state, pready comes from a flop
   assign wr = psel && penable && pready && pwrite;

   always_comb begin
      ev = '0;
      ev[EV_MASK_TAKE] = take && !off_nmi;
      ev[EV_NMI_TAKE] = take && off_nmi;
      ev[EV_PREEMPT] = take && (cur_rank != RANK_NONE);
   end

   always_comb begin
      mapped = 1'b1;
      rdata = '0;
      case (paddr)
         OFS_EN_A: rdata = 32'(int_enable_reg_a);
         OFS_EN_B: rdata = 32'(int_enable_reg_b);
         OFS_NMI_CTL: rdata = 32'(nonmaskable_control_reg);
         OFS_PL_A: rdata = 32'(prio_low_reg_a);
         OFS_PH_A: rdata = 32'(prio_high_reg_a);
         OFS_PL_B: rdata = 32'(prio_low_reg_b);
         OFS_PH_B: rdata = 32'(prio_high_reg_b);
         OFS_STATUS: rdata = 32'(status);
         OFS_MASK: rdata = 32'(mask);
         OFS_ACTIVE: rdata = 32'(isr);
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      next_int_enable_reg_a = int_enable_reg_a;
      next_int_enable_reg_b = int_enable_reg_b;
      next_nonmaskable_control_reg = nonmaskable_control_reg;
      next_prio_low_reg_a = prio_low_reg_a;
      next_prio_high_reg_a = prio_high_reg_a;
      next_prio_low_reg_b = prio_low_reg_b;
      next_prio_high_reg_b = prio_high_reg_b;
      next_mask = mask;
      // events are or-ed in after the clear so a same-cycle event survives
      next_status = status | ev;
      if (wr) begin
         case (paddr)
            OFS_EN_A: next_int_enable_reg_a = pwdata[NA-1:0];
            OFS_EN_B: next_int_enable_reg_b = pwdata[NB-1:0];
            OFS_NMI_CTL: next_nonmaskable_control_reg = pwdata[NNMI-1:0];
            OFS_PL_A: next_prio_low_reg_a = pwdata[NA-1:0];
            OFS_PH_A: next_prio_high_reg_a = pwdata[NA-1:0];
            OFS_PL_B: next_prio_low_reg_b = pwdata[NB-1:0];
            OFS_PH_B: next_prio_high_reg_b = pwdata[NB-1:0];
            OFS_STATUS: next_status = (status & ~pwdata[EV_W-1:0]) | ev;
            OFS_MASK: next_mask = pwdata[EV_W-1:0];
            default: next_mask = mask;
         endcase
      end
      next_pready = psel && penable && !pready;
      next_pslverr = next_pready && !mapped;
      next_prdata = (next_pready && !pwrite) ? rdata : '0;
      next_irq = |(next_status & next_mask);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         int_enable_reg_a <= RST_REG[NA-1:0];
         int_enable_reg_b <= RST_REG[NB-1:0];
         nonmaskable_control_reg <= RST_REG[NNMI-1:0];
         prio_low_reg_a <= RST_REG[NA-1:0];
         prio_high_reg_a <= RST_REG[NA-1:0];
         prio_low_reg_b <= RST_REG[NB-1:0];
         prio_high_reg_b <= RST_REG[NB-1:0];
         status <= RST_REG[EV_W-1:0];
         mask <= RST_REG[EV_W-1:0];
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
         irq <= 1'b0;
      end else begin
         int_enable_reg_a <= next_int_enable_reg_a;
         int_enable_reg_b <= next_int_enable_reg_b;
         nonmaskable_control_reg <= next_nonmaskable_control_reg;
         prio_low_reg_a <= next_prio_low_reg_a;
         prio_high_reg_a <= next_prio_high_reg_a;
         prio_low_reg_b <= next_prio_low_reg_b;
         prio_high_reg_b <= next_prio_high_reg_b;
         status <= next_status;
         mask <= next_mask;
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
         irq <= next_irq;
      end
   end

   property p_vec_node;
      @(posedge mclk) disable iff (!rst_b)
      vec_valid && !off_nmi |-> vec_addr == vic_vec(off_idx);
   endproperty
   a_vec_node: assert property (p_vec_node)
      else $error("node vector address wrong");

   property p_vec_nmi;
      @(posedge mclk) disable iff (!rst_b)
      vec_valid && off_nmi |-> vec_addr == VEC_NMI;
   endproperty
   a_vec_nmi: assert property (p_vec_nmi)
      else $error("nmi vector address wrong");

   property p_enable_gate;
      @(posedge mclk) disable iff (!rst_b)
      take |-> (off_nmi ? |(nmi_src & nonmaskable_control_reg) : en_all[off_idx]);
   endproperty
   a_enable_gate: assert property (p_enable_gate)
      else $error("vector taken for disabled source");

   property p_group5;
      @(posedge mclk) disable iff (!rst_b)
      st == VIC_IDLE && isr == '0 && nmi_src == '0 && (frac_div_req || lin_req)
      && int_enable_reg_a[GRP_NODE] && (req_all & en_all) == (14'h0001 << GRP_NODE)
      |=> vec_valid && !off_nmi && off_idx == 4'(GRP_NODE);
   endproperty
   a_group5: assert property (p_group5)
      else $error("shared node five not offered");

   property p_nmi_first;
      @(posedge mclk) disable iff (!rst_b)
      st == VIC_IDLE && |(nmi_src & nonmaskable_control_reg) && !isr[NMI_BIT]
      |=> vec_valid && off_nmi && vec_addr == VEC_NMI;
   endproperty
   a_nmi_first: assert property (p_nmi_first)
      else $error("nmi not offered first");

   property p_strict_higher;
      @(posedge mclk) disable iff (!rst_b)
      take |-> off_rank > cur_rank;
   endproperty
   a_strict_higher: assert property (p_strict_higher)
      else $error("preempted by equal or lower level");

   property p_top_level;
      @(posedge mclk) disable iff (!rst_b)
      cur_rank == RANK_TOP && take |-> off_nmi;
   endproperty
   a_top_level: assert property (p_top_level)
      else $error("topmost level preempted by maskable");

   property p_level_code;
      @(posedge mclk) disable iff (!rst_b)
      take && !off_nmi |-> off_rank == vic_node_rank(off_idx, pl_all, ph_all);
   endproperty
   a_level_code: assert property (p_level_code)
      else $error("granted level not formed from high and low bits");

   property p_record;
      @(posedge mclk) disable iff (!rst_b)
      take && !cpu_reti |=> act_rank == $past(off_rank) && !vec_valid;
   endproperty
   a_record: assert property (p_record)
      else $error("active level not recorded after grant");
endmodule

// ### logic/vic_pkg.sv
package vic_pkg;
   localparam int NODES = 14;
   localparam int NA = 6;
   localparam int NB = 8;
   localparam int NNMI = 6;
   localparam int GRP_NODE = 5;
   localparam int EV_W = 3;
   localparam int ISR_W = 5;
   localparam int NMI_BIT = 4;
   localparam logic [15:0] VEC_NMI = 16'h0073;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam int VEC_SH = 3;
   localparam logic [2:0] RANK_NONE = 3'h0;
   localparam logic [2:0] RANK_TOP = 3'h4;
   localparam logic [2:0] RANK_NMI = 3'h5;
   localparam logic [7:0] OFS_EN_A = 8'h00;
   localparam logic [7:0] OFS_EN_B = 8'h04;
   localparam logic [7:0] OFS_NMI_CTL = 8'h08;
   localparam logic [7:0] OFS_PL_A = 8'h0C;
   localparam logic [7:0] OFS_PH_A = 8'h10;
   localparam logic [7:0] OFS_PL_B = 8'h14;
   localparam logic [7:0] OFS_PH_B = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_ACTIVE = 8'h24;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam int EV_MASK_TAKE = 0;
   localparam int EV_NMI_TAKE = 1;
   localparam int EV_PREEMPT = 2;

   typedef enum logic [1:0] {
      VIC_IDLE = 2'b01,
      VIC_OFFER = 2'b10
   } vic_state_t;

   // high priority bit is the upper bit of the level
   function automatic logic [2:0] vic_node_rank(input logic [3:0] idx,
         input logic [NODES-1:0] pl, input logic [NODES-1:0] ph);
      return {1'b0, ph[idx], pl[idx]} + 3'h1;
   endfunction

   function automatic logic [15:0] vic_vec(input logic [3:0] idx);
      return VEC_BASE + ({12'h000, idx} << VEC_SH);
   endfunction

   function automatic logic [2:0] vic_top_rank(input logic [ISR_W-1:0] isr);
      logic [2:0] r;
      r = RANK_NONE;
      for (int i = 0; i < ISR_W; i++) begin
         if (isr[i]) begin
            r = 3'(i + 1);
         end
      end
      return r;
   endfunction
endpackage

// ### logic/vic_arb.sv
`timescale 1ns/100ps
module vic_arb (
   input wire logic [vic_pkg::NODES-1:0] req,
   input wire logic [vic_pkg::NODES-1:0] en,
   input wire logic [vic_pkg::NODES-1:0] pl,
   input wire logic [vic_pkg::NODES-1:0] ph,
   input wire logic [vic_pkg::NNMI-1:0] nmi_req,
   input wire logic [vic_pkg::NNMI-1:0] nmi_en,
   input wire logic [2:0] cur_rank,
   output logic win_ok,
   output logic win_nmi,
   output logic [3:0] win_idx,
   output logic [2:0] win_rank
);
   import vic_pkg::*;

   logic [2:0] r;

   always_comb begin
      r = RANK_NONE;
      win_idx = 4'h0;
      win_rank = RANK_NONE;
      win_nmi = 1'b0;
      // walking downward with >= lets the lower node win a tie
      for (int i = NODES - 1; i >= 0; i--) begin
         r = vic_node_rank(4'(i), pl, ph);
         if (req[i] && en[i] && r >= win_rank) begin
            win_rank = r;
            win_idx = 4'(i);
         end
      end
      if (|(nmi_req & nmi_en)) begin
         win_nmi = 1'b1;
         win_rank = RANK_NMI;
      end
      win_ok = win_rank > cur_rank;
   end
endmodule

// ### tb/vic_cpu_model.sv
`timescale 1ns/100ps
module vic_cpu_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic vec_valid,
   input wire logic [15:0] vec_addr,
   input wire logic [3:0] ack_wait,
   output logic cpu_ack,
   output logic [15:0] taken_addr,
   output logic [7:0] taken_cnt
);
   logic [3:0] wait_cnt;
   logic [3:0] next_wait_cnt;
   logic next_cpu_ack;

   // a slow core leaves the offer standing, so vec_addr must hold meanwhile
   always_comb begin
      next_wait_cnt = (vec_valid && !cpu_ack) ? wait_cnt + 4'h1 : 4'h0;
      next_cpu_ack = vec_valid && !cpu_ack && (wait_cnt >= ack_wait);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wait_cnt <= 4'h0;
         cpu_ack <= 1'b0;
         taken_addr <= 16'h0000;
         taken_cnt <= 8'h00;
      end else begin
         wait_cnt <= next_wait_cnt;
         cpu_ack <= next_cpu_ack;
         if (cpu_ack && vec_valid) begin
            taken_addr <= vec_addr;
            taken_cnt <= taken_cnt + 8'h01;
         end
      end
   end
endmodule

// ### tb/vic_top_tb_top.sv
`timescale 1ns/100ps
module vic_top_tb_top;
   import vic_pkg::*;
   logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, e;
   logic cpu_ack, cpu_reti, frac_div_req, lin_req, vec_valid, irq;
   logic [7:0] paddr, taken_cnt;
   logic [31:0] pwdata, prdata, q;
   logic [NODES-1:0] node_req;
   logic [NNMI-1:0] nmi_src;
   logic [15:0] vec_addr, taken_addr;
   logic [2:0] act_rank;
   logic [3:0] ack_wait;
   logic [7:0] ofs [10] = '{OFS_EN_A, OFS_EN_B, OFS_NMI_CTL, OFS_PL_A, OFS_PH_A,
      OFS_PL_B, OFS_PH_B, OFS_STATUS, OFS_MASK, OFS_ACTIVE};
   logic [31:0] rwm [10] = '{32'h3F, 32'hFF, 32'h3F, 32'h3F, 32'h3F, 32'hFF, 32'hFF,
      32'h0, 32'h7, 32'h0};
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   logic [7:0] n_exp = 8'h00;

   vic_top i_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .node_req(node_req), .frac_div_req(frac_div_req),
      .lin_req(lin_req), .nmi_src(nmi_src), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti),
      .vec_valid(vec_valid), .vec_addr(vec_addr), .act_rank(act_rank), .irq(irq));
   vic_cpu_model i_cpu (.mclk(mclk), .rst_b(rst_b), .vec_valid(vec_valid),
      .vec_addr(vec_addr), .ack_wait(ack_wait), .cpu_ack(cpu_ack),
      .taken_addr(taken_addr), .taken_cnt(taken_cnt));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // hang guard, far above the fewer than one thousand cycles the sequence needs
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("prdata", q, exp);
   endtask

   task automatic en_node(input int i);
      wr(OFS_EN_A, (i < NA) ? 32'h1 << i : 32'h0);
      wr(OFS_EN_B, (i < NA) ? 32'h0 : 32'h1 << (i - NA));
   endtask

   // counts expected takes, so a take that lands before the call is still seen once
   task automatic take(input logic [15:0] va, input logic [2:0] rk);
      int t;
      n_exp = n_exp + 8'h01;
      t = 0;
      while (taken_cnt !== n_exp && t < 40) begin
         @(posedge mclk);
         t++;
      end
      chk("vector count", {24'h0, taken_cnt}, {24'h0, n_exp});
      chk("vector", {16'h0, taken_addr}, {16'h0, va});
      repeat (2) @(posedge mclk);
      chk("act_rank", {29'h0, act_rank}, {29'h0, rk});
      chk("vec_valid", {31'h0, vec_valid}, 32'h0);
   endtask

   task automatic no_take();
      repeat (8) @(posedge mclk);
      chk("no vector", {24'h0, taken_cnt}, {24'h0, n_exp});
   endtask

   task automatic req(input logic [NODES-1:0] r);
      @(posedge mclk);
      node_req <= r;
   endtask

   task automatic ret();
      @(posedge mclk);
      cpu_reti <= 1'b1;
      @(posedge mclk);
      cpu_reti <= 1'b0;
   endtask

   initial begin
      {rst_b, psel, penable, pwrite, frac_div_req, lin_req, cpu_reti} = 7'h00;
      {paddr, pwdata, node_req, nmi_src, ack_wait} = '0;
      repeat (20) @(posedge mclk);
      chk("vec_addr", {16'h0, vec_addr}, 32'h3);
      rst_b <= 1'b1;
      for (int k = 0; k < 10; k++) begin
         rd(ofs[k], 32'h0);
         wr(ofs[k], 32'hFFFF_FFFF);
         rd(ofs[k], rwm[k]);
         wr(ofs[k], 32'h0);
      end
      rd(8'h28, 32'h0);
      chk("pslverr", {31'h0, e}, 32'h1);
      $display("test registers done");
      for (int i = 0; i < NODES; i++) begin
         ack_wait <= 4'(i % 4);
         req(14'h0001 << i);
         no_take();
         en_node(i);
         take(VEC_BASE + 16'(i * 8), 3'h1);
         req(14'h0000);
         ret();
      end
      en_node(GRP_NODE);
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         {lin_req, frac_div_req} <= k ? 2'b10 : 2'b01;
         take(16'h002B, 3'h1);
         {lin_req, frac_div_req} <= 2'b00;
         ret();
      end
      @(posedge mclk);
      nmi_src <= 6'h3F;
      no_take();
      nmi_src <= 6'h00;
      wr(OFS_NMI_CTL, 32'h3F);
      for (int j = 0; j < NNMI; j++) begin
         @(posedge mclk);
         nmi_src <= 6'h01 << j;
         take(VEC_NMI, RANK_NMI);
         nmi_src <= 6'h00;
         ret();
      end
      $display("test vectors done");
      wr(OFS_EN_A, 32'h3F);
      wr(OFS_EN_B, 32'hFF);
      wr(OFS_PL_A, 32'h03);
      wr(OFS_PH_A, 32'h01);
      wr(OFS_PH_B, 32'h84);
      req(14'h2002);
      take(16'h006B, 3'h3);
      req(14'h2102);
      no_take();
      req(14'h0102);
      ret();
      take(16'h0043, 3'h3);
      req(14'h0002);
      ret();
      take(16'h000B, 3'h2);
      req(14'h0102);
      take(16'h0043, 3'h3);
      req(14'h0000);
      ret();
      ret();
      req(14'h0001);
      take(16'h0003, RANK_TOP);
      req(14'h3FFF);
      no_take();
      @(posedge mclk);
      nmi_src <= 6'h01;
      take(VEC_NMI, RANK_NMI);
      rd(OFS_ACTIVE, 32'h18);
      nmi_src <= 6'h00;
      req(14'h0000);
      ret();
      ret();
      req(14'h0208);
      take(16'h001B, 3'h1);
      req(14'h0000);
      ret();
      wr(OFS_PL_B, 32'h08);
      req(14'h0208);
      take(16'h004B, 3'h2);
      req(14'h0000);
      ret();
      $display("test priority done");
      rd(OFS_STATUS, 32'h7);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(OFS_MASK, 32'h2);
      repeat (2) @(posedge mclk);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(OFS_STATUS, 32'h2);
      rd(OFS_STATUS, 32'h5);
      chk("irq", {31'h0, irq}, 32'h0);
      $display("test interrupt done");
      tally_and_finish();
   end
endmodule
